// ==== design/dit_pkg.sv ====
`default_nettype none
// =====================================================
// Shared constants for the digital I/O and totalizer
package dit_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00; // Totalizer control
    localparam logic [7:0] OFS_COUNT = 8'h04; // Totalizer snapshot
    localparam logic [7:0] OFS_PIN = 8'h08; // Live pin levels
    localparam logic [7:0] OFS_OUT = 8'h0c; // 16-bit output word
    localparam logic [7:0] OFS_OE = 8'h10; // Output enables
    localparam logic [7:0] OFS_ACFG = 8'h14; // Alarm config
    localparam logic [7:0] OFS_APAT = 8'h18; // Alarm pattern
    localparam logic [7:0] OFS_AMSK = 8'h1c; // Alarm compare mask
    localparam logic [7:0] OFS_STAT = 8'h20; // Sticky events
    localparam logic [7:0] OFS_IMSK = 8'h24; // Interrupt mask
    localparam logic [7:0] OFS_SCAN = 8'h28; // Scan capture
    localparam logic [7:0] OFS_SPIN = 8'h2c; // Scanned pin levels
    // Control fields
    localparam int CTRL_FALL = 0; // 1: count falling edges
    localparam int CTRL_CLR = 1; // Write 1: clear count
    localparam int ACFG_CHG0 = 0; // Port 0 alarm on change
    localparam int ACFG_CHG1 = 1; // Port 1 alarm on change
    localparam int ACFG_EN0 = 2; // Port 0 alarm enable
    localparam int ACFG_EN1 = 3; // Port 1 alarm enable
    // Status bits
    localparam int ST_ALM0 = 0; // Port 0 alarm
    localparam int ST_ALM1 = 1; // Port 1 alarm
    localparam int ST_WRAP = 2; // Totalizer wrapped
    localparam int ST_SCAN = 3; // Scan capture done
    localparam int ST_W = 4; // Status width
    // Widths and reset values
    localparam int CNT_W = 26; // Totalizer width
    localparam int PORT_W = 8; // Port width
    localparam logic [25:0] CNT_MAX = 26'h3ffffff; // All ones
    localparam logic [31:0] RST_ZERO = 32'h0000_0000; // Reset value
    // Timing: 100 kHz rate at 40 MHz gives 400 cycles/pulse
    localparam int CLK_HZ = 40_000_000; // Core clock rate
    localparam int PULSE_MAX_HZ = 100_000; // Max pulse rate
    localparam int CYC_PER_PULSE = CLK_HZ / PULSE_MAX_HZ; // Margin
endpackage
`default_nettype wire

// ==== design/dit_top.sv ====
`default_nettype none
module dit_top (
    input wire logic core_clk, // 40 MHz clock
    input wire logic sys_rst, // Sync reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic pulse_in, // Totalizer pulse pin
    input wire logic gate_hi, // Gate, high enables
    input wire logic gate_lo_n, // Gate, low enables
    input wire logic scan_trig, // Scan step strobe
    input wire logic [15:0] dio_in, // Port pin levels
    output logic [15:0] dio_out, // Port drive levels
    output logic [15:0] dio_oe, // Port drive enables
    output logic irq // Level interrupt
);
    // =====================================================
    // State record
    typedef struct packed {
        logic [2:0] pls_sync; // Pulse sync, [2] = last
        logic [1:0] gh_sync; // High gate sync
        logic [1:0] gl_sync; // Low gate sync
        logic [15:0] din_s1; // Port sync stage 1
        logic [15:0] din_s2; // Port sync stage 2
        logic [15:0] din_prev; // Previous sample
        logic [25:0] cnt; // Totalizer count
        logic [25:0] scan_cnt; // Scanned count
        logic [15:0] scan_pins; // Scanned pins
        logic fall_sel; // Edge select
        logic [15:0] out_word; // Output word
        logic [15:0] oe; // Output enables
        logic [3:0] acfg; // Alarm config
        logic [15:0] apat; // Alarm pattern
        logic [15:0] amsk; // Alarm mask
        logic [3:0] stat; // Sticky status
        logic [3:0] imsk; // Interrupt mask
        logic [31:0] rdata; // Read data
    } dit_state_s;

    dit_state_s st_q, st_d;
    logic acc; // Access-phase strobe
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic edge_seen; // Qualifying pulse edge
    logic gate_ok; // Both gates enabling
    logic [3:0] ev; // Events this cycle
    logic [15:0] hit; // Masked compare
    logic [15:0] chg; // Masked change

    // =====================================================
    // Register map
    // 0x00 control: bit 0 falling-edge select, bit 1 clears
    //      the count when written as one (reads back zero)
    // 0x04 count: live count, latched in the setup cycle
    // 0x08 pins: synchronised levels of both ports
    // 0x0c output word: bits 7:0 port 0, bits 15:8 port 1
    // 0x10 output enables: one bit per pin, one drives
    // 0x14 alarm config: change mode and enable per port
    // 0x18 alarm pattern, 0x1c alarm compare mask
    // 0x20 status: sticky events, write one to clear
    // 0x24 interrupt mask, same layout as status
    // 0x28 scanned count, 0x2c scanned pin levels
    // Anything above 0x2c or misaligned answers with an
    // error and has no effect.
    //
    // Hazards kept in mind:
    // - pins and gates come from the field, so every one of
    //   them passes two flops before any decision uses it
    // - the pulse needs a third flop so the edge detector
    //   compares two settled samples, never a raw pin
    // - a status event in the cycle of its clear survives,
    //   so software never loses an event it did not see
    // - the match alarm is a level: it re-sets its bit each
    //   cycle while the pattern holds, so clearing it only
    //   sticks once the pattern is gone or the alarm is off
    // - a scan step and a count read both take the count
    //   in one cycle, so no half-updated value is returned
    //
    // Limitation: the counter has no shortcut for testing
    // the wrap; reaching all ones takes 2**26 - 1 real edges.

    // =====================================================
    // Next-state logic
    // One flat process keeps every register in one place;
    // the APB answer is always zero-wait.
    always_comb begin
        st_d = st_q;
        acc = psel && penable;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        // Synchronisers, first stage only feeds second
        st_d.pls_sync = {st_q.pls_sync[1:0], pulse_in};
        st_d.gh_sync = {st_q.gh_sync[0], gate_hi};
        st_d.gl_sync = {st_q.gl_sync[0], gate_lo_n};
        st_d.din_s1 = dio_in;
        st_d.din_s2 = st_q.din_s1;
        st_d.din_prev = st_q.din_s2;
        // Edge from two synchronised samples
        if (st_q.fall_sel) begin
            edge_seen = st_q.pls_sync[2] && !st_q.pls_sync[1];
        end else begin
            edge_seen = !st_q.pls_sync[2] && st_q.pls_sync[1];
        end
        // Floating gates are pulled to enabling off-chip
        gate_ok = st_q.gh_sync[1] && !st_q.gl_sync[1];
        ev = 4'h0;
        // Counter; 3-cycle sync limits rate far above 100 kHz
        if (edge_seen && gate_ok) begin
            st_d.cnt = st_q.cnt + 26'h0000001;
            if (st_q.cnt == dit_pkg::CNT_MAX) begin
                ev[dit_pkg::ST_WRAP] = 1'b1;
            end
        end
        // Alarms run regardless of scanning
        hit = (st_q.din_s2 ^ st_q.apat) & st_q.amsk;
        chg = (st_q.din_s2 ^ st_q.din_prev) & st_q.amsk;
        if (st_q.acfg[dit_pkg::ACFG_EN0]) begin
            if (st_q.acfg[dit_pkg::ACFG_CHG0]) begin
                ev[dit_pkg::ST_ALM0] = |chg[7:0];
            end else begin
                ev[dit_pkg::ST_ALM0] = ~|hit[7:0];
            end
        end
        if (st_q.acfg[dit_pkg::ACFG_EN1]) begin
            if (st_q.acfg[dit_pkg::ACFG_CHG1]) begin
                ev[dit_pkg::ST_ALM1] = |chg[15:8];
            end else begin
                ev[dit_pkg::ST_ALM1] = ~|hit[15:8];
            end
        end
        // Scan step captures count and pins together
        if (scan_trig) begin
            st_d.scan_cnt = st_q.cnt;
            st_d.scan_pins = st_q.din_s2;
            ev[dit_pkg::ST_SCAN] = 1'b1;
        end
        // =====================================================
        // Register writes
        // A write lands at the end of the access phase; the
        // slave never stalls, so that is the first access edge.
        if (wr) begin
            unique case (paddr)
                dit_pkg::OFS_CTRL: begin
                    // Edge select changes only while software
                    // knows the pulse level, else a false edge
                    st_d.fall_sel = pwdata[dit_pkg::CTRL_FALL];
                    if (pwdata[dit_pkg::CTRL_CLR]) begin
                        st_d.cnt = 26'h0000000; // Clear beats edge
                    end
                end
                dit_pkg::OFS_OUT: begin
                    // Both ports move in the same cycle
                    st_d.out_word = pwdata[15:0];
                end
                dit_pkg::OFS_OE: begin
                    // Undriven pins fall back to the pull-ups
                    st_d.oe = pwdata[15:0];
                end
                dit_pkg::OFS_ACFG: begin
                    // Mode and enable per port
                    st_d.acfg = pwdata[3:0];
                end
                dit_pkg::OFS_APAT: begin
                    // Pattern compared under the mask
                    st_d.apat = pwdata[15:0];
                end
                dit_pkg::OFS_AMSK: begin
                    // Mask zero ignores the pin entirely
                    st_d.amsk = pwdata[15:0];
                end
                dit_pkg::OFS_STAT: begin
                    // Write one to clear
                    st_d.stat = st_q.stat & ~pwdata[3:0];
                end
                dit_pkg::OFS_IMSK: begin
                    // Only unmasked events reach the pin
                    st_d.imsk = pwdata[3:0];
                end
                default: begin
                    // Read-only or unmapped: ignored
                end
            endcase
        end
        // Set wins over a same-cycle clear
        st_d.stat = st_d.stat | ev;
        // =====================================================
        // Read data
        // The word is latched in the setup cycle and held
        // through the access phase, so a count read is one
        // coherent snapshot while pulses keep arriving.
        st_d.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                dit_pkg::OFS_CTRL: begin
                    // Clear bit is write-only
                    st_d.rdata = {31'h0, st_q.fall_sel};
                end
                dit_pkg::OFS_COUNT: begin
                    // Live count, frozen for this transfer
                    st_d.rdata = {6'h0, st_q.cnt};
                end
                dit_pkg::OFS_PIN: begin
                    // Synchronised levels, not the raw pins
                    st_d.rdata = {16'h0, st_q.din_s2};
                end
                dit_pkg::OFS_OUT: begin
                    // Drive word as written
                    st_d.rdata = {16'h0, st_q.out_word};
                end
                dit_pkg::OFS_OE: begin
                    // Drive enables
                    st_d.rdata = {16'h0, st_q.oe};
                end
                dit_pkg::OFS_ACFG: begin
                    // Alarm modes and enables
                    st_d.rdata = {28'h0, st_q.acfg};
                end
                dit_pkg::OFS_APAT: begin
                    // Alarm pattern
                    st_d.rdata = {16'h0, st_q.apat};
                end
                dit_pkg::OFS_AMSK: begin
                    // Alarm compare mask
                    st_d.rdata = {16'h0, st_q.amsk};
                end
                dit_pkg::OFS_STAT: begin
                    // Sticky events
                    st_d.rdata = {28'h0, st_q.stat};
                end
                dit_pkg::OFS_IMSK: begin
                    // Interrupt mask
                    st_d.rdata = {28'h0, st_q.imsk};
                end
                dit_pkg::OFS_SCAN: begin
                    // Count taken by the last scan step
                    st_d.rdata = {6'h0, st_q.scan_cnt};
                end
                dit_pkg::OFS_SPIN: begin
                    // Pins taken by the last scan step
                    st_d.rdata = {16'h0, st_q.scan_pins};
                end
                default: begin
                    // Unmapped reads return zero
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (rd) begin
            st_d.rdata = st_q.rdata; // Hold through access
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.pls_sync <= 3'h0;
            st_q.gh_sync <= 2'h3; // Gates start enabling
            st_q.gl_sync <= 2'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================
    // Outputs
    // Zero-wait slave; unmapped offsets answer with pslverr
    always_comb begin
        pready = 1'b1;
        prdata = st_q.rdata;
        pslverr = 1'b0;
        // Past the last register
        if (psel && penable && paddr > dit_pkg::OFS_SPIN) begin
            pslverr = 1'b1;
        end
        if (psel && penable && paddr[1:0] != 2'h0) begin
            pslverr = 1'b1;
        end
    end
    assign dio_out = st_q.out_word;
    assign dio_oe = st_q.oe;
    assign irq = |(st_q.stat & st_q.imsk);
endmodule
`default_nettype wire

// ==== test/dit_assertions.sv ====
`default_nettype none
// ==========================================
// Port checks for the digital I/O totalizer
module dit_assertions (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic pulse_in, // Pulse pin
    input wire logic gate_hi, // Gate high
    input wire logic gate_lo_n, // Gate low
    input wire logic scan_trig, // Scan strobe
    input wire logic [15:0] dio_in, // Pins
    input wire logic [15:0] dio_out, // Drive word
    input wire logic [15:0] dio_oe, // Enables
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic acc; // Access phase seen
    logic wr_out; // Word write
    logic wr_oe; // Enable write
    // Decode of the writes that may move the pin drivers
    assign acc = psel && penable;
    assign wr_out = acc && pwrite && paddr == dit_pkg::OFS_OUT;
    assign wr_oe = acc && pwrite && paddr == dit_pkg::OFS_OE;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_range: assert property (acc
        && paddr > dit_pkg::OFS_SPIN |-> pslverr)
        else $error("no error above map");
    a_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("no error misaligned");
    a_ok_mapped: assert property (acc && paddr <= dit_pkg::OFS_SPIN
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on map");
    a_rst_quiet: assert property ($past(sys_rst)
        |-> dio_out == 16'h0 && dio_oe == 16'h0 && !irq)
        else $error("outputs live after reset");
    a_word_write: assert property (wr_out
        |=> dio_out == $past(pwdata[15:0])) else $error("word not driven");
    a_word_hold: assert property (!wr_out |=> $stable(dio_out))
        else $error("word moved");
    a_oe_write: assert property (wr_oe
        |=> dio_oe == $past(pwdata[15:0])) else $error("enables wrong");
endmodule
bind dit_top dit_assertions u_chk (.core_clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_in,
    .gate_hi, .gate_lo_n, .scan_trig, .dio_in, .dio_out, .dio_oe, .irq);
`default_nettype wire

// ==== test/dit_pins.sv ====
`default_nettype none
// ==========================================
// Contacts, pull-ups and gate wiring at the pins
module dit_pins (
    input wire logic [15:0] dio_out, // Block drive
    input wire logic [15:0] dio_oe, // Block enables
    input wire logic [15:0] grounded, // Contacts closed
    input wire logic [1:0] gate_wired, // Gates connected
    input wire logic [1:0] gate_lvl, // Driven gate levels
    output logic [15:0] dio_in, // Pin levels
    output logic gate_hi, // Gate, high enables
    output logic gate_lo_n // Gate, low enables
);
    // Undriven open pins float high, closed contacts pull low
    assign dio_in = (dio_oe & dio_out) | (~dio_oe & ~grounded);
    // Loose gates float to their enabling level
    assign gate_hi = gate_wired[0] ? gate_lvl[0] : 1'b1;
    assign gate_lo_n = gate_wired[1] ? gate_lvl[1] : 1'b0;
endmodule
`default_nettype wire

// ==== test/dit_top_test.sv ====
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, s); fail_count++; end end
module dit_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, sys_rst, psel, penable, pwrite, pulse_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, serr, gate_hi, gate_lo_n, scan_trig, irq;
    logic [15:0] dio_in, dio_out, dio_oe, grounded;
    logic [1:0] gate_wired, gate_lvl;
    int fail_count = 0, check_count = 0;
    dit_top uut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pulse_in, .gate_hi,
        .gate_lo_n, .scan_trig, .dio_in, .dio_out, .dio_oe, .irq);
    dit_pins u_pins (.dio_out, .dio_oe, .grounded, .gate_wired,
        .gate_lvl, .dio_in, .gate_hi, .gate_lo_n);
    always #12.5 core_clk = ~core_clk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One APB transfer; an idle edge follows so strobes never double up
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        serr = pslverr;
        if (pready !== 1'b1) begin
            fail_count++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Half period of 200 cycles keeps pulses at the 100 kHz limit
    task automatic edge_to(input logic v);
        pulse_in <= v;
        repeat (200) @(posedge core_clk);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pulse_in, scan_trig} = '0;
        {grounded, gate_wired, gate_lvl} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        apb(0, dit_pkg::OFS_COUNT, 0); `CHK("count", 32'h0, rdat)
        apb(0, 8'h30, 0); `CHK("slverr", 1'b1, serr)
        repeat (3) begin edge_to(1'b1); edge_to(1'b0); end
        apb(0, dit_pkg::OFS_COUNT, 0); `CHK("count", 32'h3, rdat)
        $display("test open gates done");
        // Each gate blocks on its own; only both enabling counts
        for (int g = 0; g < 3; g++) begin
            gate_wired <= 2'b11;
            gate_lvl <= g == 0 ? 2'b00 : g == 1 ? 2'b11 : 2'b01;
            repeat (8) @(posedge core_clk);
            edge_to(1'b1);
            edge_to(1'b0);
        end
        gate_wired <= 2'b00;
        apb(0, dit_pkg::OFS_COUNT, 0); `CHK("gated", 32'h4, rdat)
        apb(1, dit_pkg::OFS_CTRL, 32'h3);
        edge_to(1'b1);
        apb(0, dit_pkg::OFS_COUNT, 0); `CHK("fall", 32'h0, rdat)
        edge_to(1'b0);
        apb(0, dit_pkg::OFS_COUNT, 0); `CHK("fall", 32'h1, rdat)
        scan_trig <= 1'b1;
        @(posedge core_clk);
        scan_trig <= 1'b0;
        apb(0, dit_pkg::OFS_SCAN, 0); `CHK("scan", 32'h1, rdat)
        apb(0, dit_pkg::OFS_SPIN, 0); `CHK("spin", 32'hffff, rdat)
        apb(0, dit_pkg::OFS_STAT, 0); `CHK("stat", 32'h8, rdat)
        apb(1, dit_pkg::OFS_STAT, 32'hf);
        $display("test totalizer done");
        grounded <= 16'h00f0;
        repeat (8) @(posedge core_clk);
        apb(0, dit_pkg::OFS_PIN, 0); `CHK("pin", 16'hff0f, rdat[15:0])
        apb(1, dit_pkg::OFS_OUT, 32'ha55a);
        apb(1, dit_pkg::OFS_OE, 32'hffff);
        repeat (4) @(posedge core_clk);
        apb(0, dit_pkg::OFS_PIN, 0); `CHK("word", 16'ha55a, rdat[15:0])
        $display("test ports done");
        // Port 0 all grounded matches pattern zero under its mask
        apb(1, dit_pkg::OFS_OE, 0);
        grounded <= 16'h00ff;
        apb(1, dit_pkg::OFS_APAT, 0);
        apb(1, dit_pkg::OFS_AMSK, 32'h00ff);
        apb(1, dit_pkg::OFS_IMSK, 32'h1);
        apb(1, dit_pkg::OFS_ACFG, 32'h4);
        @(posedge core_clk);
        `CHK("irq", 1'b1, irq)
        apb(1, dit_pkg::OFS_IMSK, 0); `CHK("irq", 1'b0, irq)
        apb(1, dit_pkg::OFS_ACFG, 0);
        apb(1, dit_pkg::OFS_STAT, 32'hf);
        apb(0, dit_pkg::OFS_STAT, 0); `CHK("stat", 32'h0, rdat)
        // One bit of port 1 changes under a change-mode alarm
        apb(1, dit_pkg::OFS_AMSK, 32'hff00);
        apb(1, dit_pkg::OFS_ACFG, 32'ha);
        grounded <= 16'h01ff;
        repeat (8) @(posedge core_clk);
        apb(0, dit_pkg::OFS_STAT, 0); `CHK("chg", 32'h2, rdat)
        $display("test alarms done");
        conclude();
    end
endmodule
`default_nettype wire
